// file: design/dcsp_codec_port.v
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/1ns
`include "dcsp_defines.vh"

// What this block does
// - Received bits land in back buffer first
// - Back buffer write moves rx data to front
// - Back buffer write is sent; runs continuously
// - Channel one has own identical buffer pair
// - Control address double written; reads first word
// - Three interrupt lines, general one always usable
// - Frame done gives one-cycle low pulse
// - Bit clock is clock/2/prescaler, up-counting
// - Transmit on bit clock rise, MSB first
// - Receive on bit clock fall, MSB first
// - Frame sync brackets all data bits
// - Disabled interface drives no serial controls
// - Clock and sync sources chosen independently
// - External clock and sync pace the transfers
// - Transmit and receive shift simultaneously
// - Channel 0 with sync 0, channel 1 sync 1
// - Word one: mode, sync, ch0; two: rest
// - 8-bit mode plain or mu-law companded
// - 16-bit linear mode sends uncompressed samples
// - Stereo frame carries 64 bits
// - Stereo receive fills all four registers
// - Disabled interface frees external address space
// - Compressor maps 13-bit linear to 8-bit
// - Prescaler timer dedicated to codec timing
module dcsp_codec_port (
  // Clock and reset
  input  wire        clk,
  input  wire        rstn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Serial link
  input  wire        sclk_i,
  output reg         sclk_o,
  output reg         sclk_oe,
  input  wire        fs0_i,
  output reg         fs0_o,
  output reg         fs0_oe,
  input  wire        fs1_i,
  output reg         fs1_o,
  output reg         fs1_oe,
  output reg         txd_o,
  input  wire        rxd_i,
  // Interrupt lines
  input  wire        general_irq_n_i,
  output reg         general_irq_n,
  output reg         codec_frame_irq_n,
  output reg         timer_irq_n,
  // System side
  output reg         ext_space_free,
  output reg         wait_state_en
);

  // ========================================================
  // Helpers
  function dcsp_mapped;
    input [7:0] a;
    begin
      dcsp_mapped = (a == `DCSP_A_F0) || (a == `DCSP_A_B0) ||
                    (a == `DCSP_A_F1) || (a == `DCSP_A_B1) ||
                    (a == `DCSP_A_CTL) || (a == `DCSP_A_STAT);
    end
  endfunction

  // Clip, bias, find segment, keep four mantissa bits, invert
  function [7:0] dcsp_mulaw;
    input [12:0] lin;
    reg   [12:0] mag;
    reg   [2:0]  seg;
    reg   [3:0]  man;
    integer      i;
    begin
      mag = lin[12] ? (~lin + 13'h0001) : lin;
      if (mag > `DCSP_MU_CLIP) begin
        mag = `DCSP_MU_CLIP;
      end
      mag = mag + `DCSP_MU_BIAS;
      seg = 3'h0;
      for (i = 6; i < 13; i = i + 1) begin
        if (mag[i]) begin
          seg = i[2:0] - 3'h5;
        end
      end
      man = 4'h0;
      for (i = 0; i < 4; i = i + 1) begin
        man[i] = mag[{1'b0, seg} + 4'h1 + i[3:0]];
      end
      dcsp_mulaw = ~{lin[12], seg, man};
    end
  endfunction

  // ========================================================
  // Registers
  reg [15:0] cw1_r;
  reg [15:0] cw2_r;
  reg        ctl_sel_r;
  reg [15:0] rxf_r [0:1];
  reg [15:0] rxb_r [0:1];
  reg [15:0] txf_r [0:1];
  reg [15:0] txb_r [0:1];
  reg [4:0]  s1_r;
  reg [4:0]  s2_r;
  reg [2:0]  s3_r;
  reg [3:0]  pre_r;
  reg        sclk_r;
  reg [1:0]  st_r;
  reg        ch_r;
  reg        nxt_ch_r;
  reg [63:0] tsh_r;
  reg [63:0] rsh_r;
  reg [6:0]  tcnt_r;
  reg [6:0]  rcnt_r;
  reg [1:0]  fs_r;
  reg [1:0]  pend_r;
  reg        done_r;
  reg        txd_r;

  wire [1:0] mode    = cw1_r[`DCSP_CW1_MODE];
  wire       stereo  = (mode == `DCSP_M_STEREO);
  wire       en0     = cw1_r[`DCSP_CW1_EN];
  wire       en1     = cw2_r[`DCSP_CW2_EN1] & ~stereo;
  wire       en_any  = en0 | en1;
  wire       fs_ext  = cw1_r[`DCSP_CW1_FSEXT];
  wire       sck_ext = cw2_r[`DCSP_CW2_SCKEXT];
  wire [3:0] ps      = cw2_r[`DCSP_CW2_PS];
  wire [6:0] len     = stereo ? `DCSP_LEN64 :
                       (mode == `DCSP_M_LIN16) ? `DCSP_LEN16 : `DCSP_LEN8;
  wire       apb_wr  = psel & penable & pready & pwrite;
  wire       hit     = dcsp_mapped(paddr);

  // ========================================================
  // Pin synchronisers: sclk, fs0, fs1, rxd, general irq
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_r <= 5'h10;
      s2_r <= 5'h10;
      s3_r <= 3'h0;
    end else begin
      s1_r <= {general_irq_n_i, rxd_i, fs1_i, fs0_i, sclk_i};
      s2_r <= s1_r;
      s3_r <= s2_r[2:0];
    end
  end

  wire ext_rise = s2_r[0] & ~s3_r[0];
  wire ext_fall = ~s2_r[0] & s3_r[0];
  wire [1:0] fs_rise = s2_r[2:1] & ~s3_r[2:1];

  // ========================================================
  // Bit clock: prescaler counts clk, the toggle is the divide by two
  wire [3:0] ps_top = ps - 4'h1;
  wire       tick   = en_any & ~sck_ext & (pre_r == ps_top);

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pre_r  <= 4'h0;
      sclk_r <= 1'b0;
    end else if (!en_any || sck_ext) begin
      pre_r  <= 4'h0;
      sclk_r <= 1'b0;
    end else if (tick) begin
      pre_r  <= 4'h0;
      sclk_r <= ~sclk_r;
    end else begin
      pre_r  <= pre_r + 4'h1;
    end
  end

  wire rise_ev = sck_ext ? ext_rise : (tick & ~sclk_r);
  wire fall_ev = sck_ext ? ext_fall : (tick & sclk_r);

  // ========================================================
  // Transmit word for a channel
  wire [15:0] txb0 = txb_r[0];
  wire [15:0] txb1 = txb_r[1];
  wire        nxt_sel;
  wire [15:0] txc  = nxt_sel ? txb1 : txb0;
  reg  [63:0] tx_word;

  always @* begin
    case (mode)
      `DCSP_M_PCM8:   tx_word = {txc[7:0], 56'h0};
      `DCSP_M_MULAW:  tx_word = {dcsp_mulaw(txc[15:3]), 56'h0};
      `DCSP_M_LIN16:  tx_word = {txc, 48'h0};
      default:        tx_word = {txf_r[0], txb0, txf_r[1], txb1};
    endcase
  end

  // Internal sync alternates channels; external sync starts whichever rose
  wire want0 = en0 & (fs_ext ? pend_r[0] : 1'b1);
  wire want1 = en1 & (fs_ext ? pend_r[1] : 1'b1);
  assign nxt_sel = want1 & (~want0 | nxt_ch_r);
  wire start = rise_ev & (want0 | want1);

  // ========================================================
  // Frame engine
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r     <= `DCSP_ST_IDLE;
      ch_r     <= 1'b0;
      nxt_ch_r <= 1'b0;
      tsh_r    <= 64'h0;
      rsh_r    <= 64'h0;
      tcnt_r   <= 7'h00;
      rcnt_r   <= 7'h00;
      fs_r     <= 2'h0;
      pend_r   <= 2'h0;
      done_r   <= 1'b0;
      txd_r    <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (!en_any) begin
        st_r   <= `DCSP_ST_IDLE;
        fs_r   <= 2'h0;
        pend_r <= 2'h0;
        txd_r  <= 1'b0;
      end else begin
        case (st_r)
          `DCSP_ST_IDLE: begin
            if (start) begin
              st_r   <= `DCSP_ST_DATA;
              ch_r   <= nxt_sel;
              tsh_r  <= tx_word;
              tcnt_r <= 7'h00;
              rcnt_r <= 7'h00;
              if (!fs_ext) begin
                fs_r[nxt_sel] <= 1'b1;
              end
            end
          end
          `DCSP_ST_DATA: begin
            if (rise_ev && tcnt_r != len) begin
              txd_r  <= tsh_r[63];
              tsh_r  <= {tsh_r[62:0], 1'b0};
              tcnt_r <= tcnt_r + 7'h01;
            end
            if (fall_ev && rcnt_r != tcnt_r) begin
              rsh_r  <= {rsh_r[62:0], s2_r[3]};
              rcnt_r <= rcnt_r + 7'h01;
              if (rcnt_r == len - 7'h01) begin
                st_r <= `DCSP_ST_END;
              end
            end
          end
          `DCSP_ST_END: begin
            if (rise_ev) begin
              fs_r     <= 2'h0;
              txd_r    <= 1'b0;
              done_r   <= 1'b1;
              nxt_ch_r <= ~ch_r;
              st_r     <= `DCSP_ST_IDLE;
            end
          end
          default: st_r <= `DCSP_ST_IDLE;
        endcase
        // A new sync edge wins over the clear at frame start
        if (start && st_r == `DCSP_ST_IDLE) begin
          pend_r[nxt_sel] <= 1'b0;
        end
        if (fs_ext) begin
          pend_r <= pend_r & ~({nxt_sel, ~nxt_sel} & {2{start &&
                    st_r == `DCSP_ST_IDLE}}) | fs_rise;
        end
      end
    end
  end

  wire store = en_any && st_r == `DCSP_ST_END && rise_ev;

  // ========================================================
  // Data and control registers
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cw1_r     <= `DCSP_CW_RST;
      cw2_r     <= `DCSP_CW_RST;
      ctl_sel_r <= 1'b0;
      rxf_r[0]  <= 16'h0000;
      rxf_r[1]  <= 16'h0000;
      rxb_r[0]  <= 16'h0000;
      rxb_r[1]  <= 16'h0000;
      txf_r[0]  <= 16'h0000;
      txf_r[1]  <= 16'h0000;
      txb_r[0]  <= 16'h0000;
      txb_r[1]  <= 16'h0000;
    end else begin
      if (apb_wr) begin
        case (paddr)
          `DCSP_A_B0: begin
            rxf_r[0] <= rxb_r[0];
            txb_r[0] <= pwdata[15:0];
          end
          `DCSP_A_B1: begin
            rxf_r[1] <= rxb_r[1];
            txb_r[1] <= pwdata[15:0];
          end
          `DCSP_A_F0: txf_r[0] <= pwdata[15:0];
          `DCSP_A_F1: txf_r[1] <= pwdata[15:0];
          `DCSP_A_CTL: begin
            ctl_sel_r <= ~ctl_sel_r;
            if (!ctl_sel_r) begin
              cw1_r <= pwdata[15:0];
            end else begin
              cw2_r <= pwdata[15:0];
            end
          end
          default: ;
        endcase
      end
      if (store) begin
        if (stereo) begin
          rxf_r[0] <= rsh_r[63:48];
          rxb_r[0] <= rsh_r[47:32];
          rxf_r[1] <= rsh_r[31:16];
          rxb_r[1] <= rsh_r[15:0];
        end else if (len == `DCSP_LEN16) begin
          rxb_r[ch_r] <= rsh_r[15:0];
        end else begin
          rxb_r[ch_r] <= {8'h00, rsh_r[7:0]};
        end
      end
    end
  end

  // ========================================================
  // APB: one access cycle, answer prepared in the setup cycle
  reg [31:0] rd_nxt;

  always @* begin
    case (paddr)
      `DCSP_A_F0:   rd_nxt = {16'h0000, rxf_r[0]};
      `DCSP_A_B0:   rd_nxt = {16'h0000, rxb_r[0]};
      `DCSP_A_F1:   rd_nxt = {16'h0000, rxf_r[1]};
      `DCSP_A_B1:   rd_nxt = {16'h0000, rxb_r[1]};
      `DCSP_A_CTL:  rd_nxt = {16'h0000, cw1_r};
      `DCSP_A_STAT: rd_nxt = {26'h0, ctl_sel_r, ch_r, st_r, en1, en0};
      default:      rd_nxt = 32'h0;
    endcase
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit;
      if (psel && !penable) begin
        prdata <= pwrite ? 32'h0 : rd_nxt;
      end
    end
  end

  // ========================================================
  // Registered pin drives and interrupt lines
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sclk_o            <= 1'b0;
      txd_o             <= 1'b0;
      sclk_oe           <= 1'b0;
      fs0_o             <= 1'b0;
      fs0_oe            <= 1'b0;
      fs1_o             <= 1'b0;
      fs1_oe            <= 1'b0;
      general_irq_n     <= 1'b1;
      codec_frame_irq_n <= 1'b1;
      timer_irq_n       <= 1'b1;
      ext_space_free    <= 1'b1;
      wait_state_en     <= 1'b0;
    end else begin
      sclk_o            <= sclk_r;
      txd_o             <= txd_r;
      sclk_oe           <= en_any & ~sck_ext;
      fs0_o             <= fs_r[0];
      fs0_oe            <= en0 & ~fs_ext;
      fs1_o             <= fs_r[1];
      fs1_oe            <= en1 & ~fs_ext;
      general_irq_n     <= s2_r[4];
      codec_frame_irq_n <= ~done_r;
      timer_irq_n       <= 1'b1;
      ext_space_free    <= ~en_any;
      wait_state_en     <= cw2_r[`DCSP_CW2_WAIT];
    end
  end

endmodule

// file: design/dcsp_defines.vh
`ifndef DCSP_DEFINES_VH
`define DCSP_DEFINES_VH
// ==========================================================
// Register map (byte addresses on APB)
`define DCSP_A_F0       8'h00
`define DCSP_A_B0       8'h04
`define DCSP_A_F1       8'h08
`define DCSP_A_B1       8'h0c
`define DCSP_A_CTL      8'h10
`define DCSP_A_STAT     8'h14
// ==========================================================
// Codec control word fields
`define DCSP_CW1_EN     0
`define DCSP_CW1_MODE   2:1
`define DCSP_CW1_FSEXT  3
// Wait-state, bit clock and channel 1 enable control word fields
`define DCSP_CW2_WAIT   0
`define DCSP_CW2_PS     4:1
`define DCSP_CW2_SCKEXT 5
`define DCSP_CW2_EN1    6
`define DCSP_CW_RST     16'h0000
// ==========================================================
// Modes and frame lengths
`define DCSP_M_PCM8     2'h0
`define DCSP_M_MULAW    2'h1
`define DCSP_M_LIN16    2'h2
`define DCSP_M_STEREO   2'h3
`define DCSP_LEN8       7'h08
`define DCSP_LEN16      7'h10
`define DCSP_LEN64      7'h40
// ==========================================================
// Companding constants (13-bit linear in)
`define DCSP_MU_BIAS    13'h0021
`define DCSP_MU_CLIP    13'h1fde
// ==========================================================
// Frame states
`define DCSP_ST_IDLE    2'h0
`define DCSP_ST_DATA    2'h1
`define DCSP_ST_END     2'h2
`endif

// file: sim/dcsp_codec_port_props.sv
`timescale 1ns/1ns
module dcsp_codec_port_props (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Bus answer
  input wire pready,
  input wire pslverr,
  // Serial link
  input wire sclk_o,
  input wire sclk_oe,
  input wire fs0_o,
  input wire fs0_oe,
  input wire fs1_o,
  input wire fs1_oe,
  input wire txd_o,
  // Interrupts and system side
  input wire general_irq_n_i,
  input wire general_irq_n,
  input wire codec_frame_irq_n,
  input wire timer_irq_n,
  input wire ext_space_free
);
default clocking cb @(posedge clk); endclocking
default disable iff (!rstn);
// ====================
// Frame end, then one low interrupt cycle
sequence s_frame_end;
  $fell(fs0_o) || $fell(fs1_o);
endsequence
sequence s_irq_pulse;
  ##[0:4] !codec_frame_irq_n ##1 codec_frame_irq_n;
endsequence
a_frame_irq: assert property (s_frame_end |-> s_irq_pulse)
  else $error("no interrupt pulse after frame end");
a_irq_single: assert property ($fell(codec_frame_irq_n) |=> codec_frame_irq_n)
  else $error("interrupt pulse longer than one cycle");
// ====================
// Wire timing: only a bit clock rise may move data or sync 0
a_txd_on_rise: assert property (sclk_oe && $changed(txd_o) |-> $rose(sclk_o))
  else $error("txd moved off a bit clock rise");
a_fs_on_rise: assert property (fs0_oe && $changed(fs0_o) |-> $rose(sclk_o))
  else $error("frame sync moved off a bit clock rise");
a_txd_framed: assert property ((fs0_oe || fs1_oe) && !fs0_o && !fs1_o
  && $past(!fs0_o && !fs1_o) |-> !txd_o)
  else $error("txd active outside frame sync");
a_quiet_off: assert property (ext_space_free |-> !fs0_o && !fs1_o && !txd_o)
  else $error("serial signals while disabled");
// ====================
// Bus and interrupt lines
a_ready_pulse: assert property (pready |=> !pready)
  else $error("pready held beyond one cycle");
a_err_ready: assert property (pslverr |-> pready)
  else $error("pslverr without pready");
a_gen_irq: assert property ($fell(general_irq_n_i) |-> ##[2:4] !general_irq_n)
  else $error("general interrupt not passed through");
a_timer_high: assert property (timer_irq_n)
  else $error("timer interrupt asserted");
endmodule

bind dcsp_codec_port dcsp_codec_port_props u_props (
  .clk(clk), .rstn(rstn), .pready(pready), .pslverr(pslverr),
  .sclk_o(sclk_o), .sclk_oe(sclk_oe), .fs0_o(fs0_o), .fs0_oe(fs0_oe),
  .fs1_o(fs1_o), .fs1_oe(fs1_oe), .txd_o(txd_o), .general_irq_n_i(general_irq_n_i),
  .general_irq_n(general_irq_n), .codec_frame_irq_n(codec_frame_irq_n),
  .timer_irq_n(timer_irq_n), .ext_space_free(ext_space_free)
);

// file: sim/dcsp_codec_model.sv
`timescale 1ns/1ns
module dcsp_codec_model #(parameter [15:0] RXW = 16'h3c96) (
  // Serial link
  input  wire        sclk,
  input  wire        fs,
  input  wire        txd,
  output reg         rxd,
  // Last word received from the device
  output reg  [15:0] tx_word
);
reg     [15:0] sh;
integer        cnt;
initial begin
  rxd = 1'b0;
  tx_word = 16'h0000;
  sh = 16'h0000;
  cnt = 0;
end
// MSB must already stand before the first sampling fall
always @(posedge fs) begin
  cnt = 0;
  rxd <= RXW[15];
end
// Fall after the sync rise carries no bit yet, so it is skipped
always @(negedge sclk) begin
  if (fs) begin
    if (cnt > 0) sh = {sh[14:0], txd};
    if (cnt < 16) rxd <= RXW[15 - cnt];
    cnt = cnt + 1;
  end
end
// Released line shows the inverse so a stale bit cannot pass
always @(negedge fs) begin
  tx_word <= sh;
  rxd <= ~rxd;
end
endmodule

// file: sim/test_dcsp_codec_port.sv
`timescale 1ns/1ns
`include "dcsp_defines.vh"
module test_dcsp_codec_port;
// ====================
// Stimulus and observed signals
reg         clk = 1'b0;
reg         rstn = 1'b0;
reg         psel = 1'b0;
reg         penable = 1'b0;
reg         pwrite = 1'b0;
reg  [7:0]  paddr = 8'h00;
reg  [31:0] pwdata = 32'h0;
reg         general_irq_n_i = 1'b1;
reg  [31:0] rd;
reg         err;
integer     miscompares = 0;
integer     num_checks = 0;
integer     n;
wire [31:0] prdata;
wire        pready, pslverr, sclk_o, sclk_oe, fs0_o, fs0_oe, fs1_o, fs1_oe, txd_o;
wire        general_irq_n, codec_frame_irq_n, timer_irq_n, ext_space_free, wait_state_en;
wire        rx0, rx1;
wire [15:0] tx0, tx1;
wire        rxd_i = fs1_o ? rx1 : rx0;
wire        sclk_i = 1'b0;
wire        fs0_i = 1'b0;
wire        fs1_i = 1'b0;
always #20 clk = ~clk;
dcsp_codec_port u_dcsp_codec_port (
  .clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .sclk_i, .sclk_o, .sclk_oe, .fs0_i, .fs0_o, .fs0_oe, .fs1_i, .fs1_o, .fs1_oe,
  .txd_o, .rxd_i, .general_irq_n_i, .general_irq_n, .codec_frame_irq_n,
  .timer_irq_n, .ext_space_free, .wait_state_en
);
dcsp_codec_model #(.RXW(16'h3c96)) m_codec0 (
  .sclk(sclk_o), .fs(fs0_o), .txd(txd_o), .rxd(rx0), .tx_word(tx0));
dcsp_codec_model #(.RXW(16'hc381)) m_codec1 (
  .sclk(sclk_o), .fs(fs1_o), .txd(txd_o), .rxd(rx1), .tx_word(tx1));
// ====================
// Tasks
task stop_test;
  begin
    if (miscompares == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  end
endtask
task hang;
  begin
    miscompares = miscompares + 1;
    stop_test;
  end
endtask
task check(input [15:0] got, input [15:0] exp);
  begin
    num_checks = num_checks + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
endtask
// One idle cycle after each transfer keeps psel from being set twice in a step
task apb(input w, input [7:0] a, input [31:0] d);
  integer k;
  begin
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && k < 50) begin
      k = k + 1;
      @(posedge clk);
    end
    if (k >= 50) hang;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  end
endtask
task wait_irq;
  integer k;
  begin
    k = 0;
    @(posedge clk);
    while (codec_frame_irq_n !== 1'b0 && k < 4000) begin
      k = k + 1;
      @(posedge clk);
    end
    if (k >= 4000) hang;
  end
endtask
task wait_sclk(input v);
  integer k;
  begin
    k = 0;
    while (sclk_o !== v && k < 100) begin
      k = k + 1;
      n = n + 1;
      @(posedge clk);
    end
    if (k >= 100) hang;
  end
endtask
// ====================
// Main sequence
initial begin
  repeat (12) @(posedge clk);
  rstn <= 1'b1;
  @(posedge clk);
  apb(1'b0, `DCSP_A_CTL, 32'h0);
  check(rd[15:0], `DCSP_CW_RST);
  check({15'h0, ext_space_free}, 16'h1);
  check({15'h0, timer_irq_n}, 16'h1);
  apb(1'b0, 8'h1c, 32'h0);
  check({15'h0, err}, 16'h1);
  // Word one: channel 0 on, 16-bit linear; word two: wait state, prescaler 4
  apb(1'b1, `DCSP_A_CTL, 32'h5);
  apb(1'b1, `DCSP_A_CTL, 32'h9);
  apb(1'b1, `DCSP_A_B0, 32'ha5c3);
  apb(1'b0, `DCSP_A_CTL, 32'h0);
  check(rd[15:0], 16'h0005);
  check({14'h0, wait_state_en, ext_space_free}, 16'h2);
  general_irq_n_i <= 1'b0;
  wait_sclk(1'b0);
  wait_sclk(1'b1);
  n = 0;
  wait_sclk(1'b0);
  wait_sclk(1'b1);
  check(n[15:0], 16'h0008);
  check({15'h0, general_irq_n}, 16'h0);
  general_irq_n_i <= 1'b1;
  wait_irq;
  wait_irq;
  check(tx0, 16'ha5c3);
  apb(1'b0, `DCSP_A_B0, 32'h0);
  check(rd[15:0], 16'h3c96);
  apb(1'b0, `DCSP_A_F0, 32'h0);
  check(rd[15:0], 16'h0000);
  apb(1'b1, `DCSP_A_B0, 32'h1234);
  apb(1'b0, `DCSP_A_F0, 32'h0);
  check(rd[15:0], 16'h3c96);
  // Second channel joins; frames now alternate between the two syncs
  apb(1'b1, `DCSP_A_CTL, 32'h5);
  apb(1'b1, `DCSP_A_CTL, 32'h49);
  apb(1'b1, `DCSP_A_B1, 32'h5a0f);
  repeat (4) wait_irq;
  check(tx1, 16'h5a0f);
  check(tx0, 16'h1234);
  apb(1'b0, `DCSP_A_B1, 32'h0);
  check(rd[15:0], 16'hc381);
  stop_test;
end
endmodule
